// ### rxsc_frame_classify.sv
// Sorts one reported frame into error counters and length bins
`timescale 1ns/1ps
`default_nettype none
module rxsc_frame_classify
  import rxsc_pkg::*;
(
  input  wire logic [LEN_W-1:0]   frameLen,
  input  wire logic               fcsBad,
  input  wire logic               dribble,
  input  wire logic               codeErr,
  output logic      [NUM_ERR-1:0] errInc,
  output logic      [NUM_BIN-1:0] binInc
);

  logic shortFrame;
  logic goodFrame;
  logic overFrame;

  // Basic length and health terms
  assign shortFrame = frameLen < LEN_64;
  assign goodFrame  = !fcsBad;
  assign overFrame  = frameLen >= LEN_16384;

  // Error classes for frames with a failed frame check
  assign errInc[ERR_ALIGN] = fcsBad && !shortFrame && dribble;
  assign errInc[ERR_CRC]   = fcsBad && !shortFrame && !dribble;
  assign errInc[ERR_CODE]  = fcsBad && !shortFrame && !dribble && codeErr;
  assign errInc[ERR_FRAG]  = fcsBad && shortFrame;

  // Length histogram, error-free frames only except the oversized bin
  assign binInc[BIN_64] = goodFrame && (frameLen == LEN_64);
  assign binInc[1] = goodFrame && rxsc_in_range(frameLen, LEN_64 + 16'h0001, LEN_127);
  assign binInc[2] = goodFrame && rxsc_in_range(frameLen, LEN_127 + 16'h0001, LEN_255);
  assign binInc[3] = goodFrame && rxsc_in_range(frameLen, LEN_255 + 16'h0001, LEN_511);
  assign binInc[4] = goodFrame && rxsc_in_range(frameLen, LEN_511 + 16'h0001, LEN_1023);
  assign binInc[5] = goodFrame && rxsc_in_range(frameLen, LEN_1023 + 16'h0001, LEN_1518);
  assign binInc[6] = goodFrame && rxsc_in_range(frameLen, LEN_1518 + 16'h0001, LEN_1522);
  assign binInc[BIN_JUMBO] = goodFrame && (frameLen > LEN_1522) && !overFrame;
  assign binInc[BIN_RUNT]  = goodFrame && shortFrame;
  assign binInc[BIN_OVER]  = overFrame;

endmodule
`default_nettype wire

// ### rxsc_frame_src.sv
// Receive MAC side model that reports frames to the statistics counters
`timescale 1ns/1ps
`default_nettype none
module rxsc_frame_src
  import rxsc_pkg::*;
(
  input  wire logic              clock,
  output logic                   frameValid,
  output logic      [PORT_W-1:0] framePort,
  output logic      [LEN_W-1:0]  frameLen,
  output logic                   frameFcsBad,
  output logic                   frameDribble,
  output logic                   frameCodeErr
);
  // Quiet lines at time zero
  initial begin
    frameValid = 1'b0;
    {framePort, frameLen, frameFcsBad, frameDribble, frameCodeErr} = '0;
  end

  // One report per call; calls in a row give back-to-back reports
  task automatic send(input logic [PORT_W-1:0] p, input logic [LEN_W-1:0] l,
                      input logic [2:0] f);
    @(posedge clock);
    frameValid <= 1'b1;
    framePort  <= p;
    frameLen   <= l;
    {frameFcsBad, frameDribble, frameCodeErr} <= f;
  endtask

  // Released lines show the inverse of the last report, so stale data never matches
  task automatic idle();
    @(posedge clock);
    frameValid <= 1'b0;
    {framePort, frameLen, frameFcsBad, frameDribble, frameCodeErr} <=
      ~{framePort, frameLen, frameFcsBad, frameDribble, frameCodeErr};
  endtask
endmodule
`default_nettype wire

// ### rxsc_pkg.sv
// Constants, register map and types for the receive statistics counters
// Functional notes
// - Each of 50 ports keeps a 28-bit received byte total, bit 4 up, bad-FCS frames included.
// - Alignment errors count frames of at least 64 bytes with bad FCS and dribble bits.
// - CRC errors count frames of at least 64 bytes with bad FCS, no dribble.
// - Code errors count frames of 64+ bytes, no dribble, bad FCS and code error.
// - Fragments count bad-FCS frames under 64 bytes, code errors or dribble regardless.
// - Every counter wraps from all ones to zero silently, with no flag.
// - Counter widths allow at most one wrap between samples ten times a second.
// - Counter index equals port number; 0-47 gigabit ports, 48 and 49 ten-gig ports.
// - Histogram counts error-free frames in bins 64, 65-127 up to 1519-1522 bytes.
// - Error-free frames over 1522 and under 16384 bytes go to the jumbo bin.
// - Error-free frames under 64 bytes go to the separate runt bin.
// - Frames of any kind of 16384 bytes or more go to the oversized bin.
package rxsc_pkg;

  localparam int NUM_PORTS = 50;
  localparam int PORT_W    = 6;
  localparam int ADDR_W    = 20;
  localparam int LEN_W     = 16;
  localparam int OCTET_W   = 28;
  localparam int CNT_W     = 22;
  localparam int NUM_ERR   = 4;
  localparam int NUM_BIN   = 10;
  localparam int IDX_W     = 4;

  // Ports 48 and 49 are the ten-gig ports
  localparam logic [PORT_W-1:0] TEN_GIG_PORT0 = 6'h30;
  localparam logic [PORT_W-1:0] TEN_GIG_PORT1 = 6'h31;

  // Region bases and sizes, byte addresses
  localparam logic [ADDR_W-1:0] BIN_BASE      = 20'h4_4000;
  localparam logic [ADDR_W-1:0] ERR_BASE      = 20'h4_5800;
  localparam logic [ADDR_W-1:0] OCTET_BASE    = 20'h4_6400;
  localparam logic [ADDR_W-1:0] BIN_MAIN_SIZE = 20'h0_0640;
  localparam logic [ADDR_W-1:0] BIN_SIZE      = 20'h0_07D0;
  localparam logic [ADDR_W-1:0] ERR_SIZE      = 20'h0_0320;
  localparam logic [ADDR_W-1:0] OCTET_SIZE    = 20'h0_00C8;

  // Field positions inside a 32-bit slot
  localparam int OCTET_LSB = 4;
  localparam int CNT_LSB   = 10;

  // Values after reset
  localparam logic [OCTET_W-1:0] OCTET_RESET = 28'h000_0000;
  localparam logic [CNT_W-1:0]   CNT_RESET   = 22'h00_0000;

  // Error counter slots within a 16-byte port record
  localparam int ERR_ALIGN = 0;
  localparam int ERR_CRC   = 1;
  localparam int ERR_CODE  = 2;
  localparam int ERR_FRAG  = 3;

  // Histogram slots; 0..7 main record, 8 and 9 the separate area
  localparam int BIN_64    = 0;
  localparam int BIN_JUMBO = 7;
  localparam int BIN_RUNT  = 8;
  localparam int BIN_OVER  = 9;

  // Length limits in bytes
  localparam logic [LEN_W-1:0] LEN_64    = 16'h0040;
  localparam logic [LEN_W-1:0] LEN_127   = 16'h007F;
  localparam logic [LEN_W-1:0] LEN_255   = 16'h00FF;
  localparam logic [LEN_W-1:0] LEN_511   = 16'h01FF;
  localparam logic [LEN_W-1:0] LEN_1023  = 16'h03FF;
  localparam logic [LEN_W-1:0] LEN_1518  = 16'h05EE;
  localparam logic [LEN_W-1:0] LEN_1522  = 16'h05F2;
  localparam logic [LEN_W-1:0] LEN_16384 = 16'h4000;

  typedef enum logic [1:0] {
    RXSC_NONE  = 2'b00,
    RXSC_OCTET = 2'b01,
    RXSC_ERR   = 2'b10,
    RXSC_BIN   = 2'b11
  } rxsc_region_t;

  // True when a length lies within an inclusive range
  function automatic logic rxsc_in_range(input logic [LEN_W-1:0] len,
                                         input logic [LEN_W-1:0] lo,
                                         input logic [LEN_W-1:0] hi);
    rxsc_in_range = (len >= lo) && (len <= hi);
  endfunction

endpackage

// ### rxsc_stat_counters.sv
// Per-port receive statistics counters with supervisor register port
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module rxsc_stat_counters
  import rxsc_pkg::*;
#(
  parameter int NPORTS = NUM_PORTS
) (
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire logic              frameValid,
  input  wire logic [PORT_W-1:0] framePort,
  input  wire logic [LEN_W-1:0]  frameLen,
  input  wire logic              frameFcsBad,
  input  wire logic              frameDribble,
  input  wire logic              frameCodeErr,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [31:0]       regWdata,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output logic      [31:0]       regRdata
);

  // Counter storage
  logic [OCTET_W-1:0] octetTotal [NPORTS];
  logic [CNT_W-1:0]   errCount   [NPORTS][NUM_ERR];
  logic [CNT_W-1:0]   binCount   [NPORTS][NUM_BIN];

  logic [NUM_ERR-1:0] errInc;
  logic [NUM_BIN-1:0] binInc;
  logic               frameOk;

  logic [ADDR_W-1:0]  offBin;
  logic [ADDR_W-1:0]  offExtra;
  logic [ADDR_W-1:0]  offErr;
  logic [ADDR_W-1:0]  offOct;
  logic               aligned;
  logic               inBin;
  logic               inBinMain;
  logic               inErr;
  logic               inOct;
  logic [PORT_W-1:0]  binPort;
  logic [IDX_W-1:0]   binIdx;
  rxsc_region_t       region;
  logic [PORT_W-1:0]  selPort;
  logic [IDX_W-1:0]   selIdx;
  logic               wrOct;
  logic               wrErr;
  logic               wrBin;
  logic [31:0]        next_regRdata;

  // Frame sorting
  rxsc_frame_classify u_classify (
    .frameLen (frameLen),
    .fcsBad   (frameFcsBad),
    .dribble  (frameDribble),
    .codeErr  (frameCodeErr),
    .errInc   (errInc),
    .binInc   (binInc)
  );

  // Counter index is the port number; unknown ports are dropped
  assign frameOk = frameValid && (framePort < PORT_W'(NPORTS));

  // Address offsets within each region
  assign offBin   = regAddr - BIN_BASE;
  assign offExtra = offBin - BIN_MAIN_SIZE;
  assign offErr   = regAddr - ERR_BASE;
  assign offOct   = regAddr - OCTET_BASE;
  assign aligned  = regAddr[1:0] == 2'b00;

  // Region hits, each word-aligned
  assign inBin     = aligned && (regAddr >= BIN_BASE) && (offBin < BIN_SIZE);
  assign inBinMain = offBin < BIN_MAIN_SIZE;
  assign inErr     = aligned && (regAddr >= ERR_BASE) && (offErr < ERR_SIZE);
  assign inOct     = aligned && (regAddr >= OCTET_BASE) && (offOct < OCTET_SIZE);

  // Histogram slot: 32-byte main record or 8-byte separate record
  assign binPort = inBinMain ? offBin[10:5] : offExtra[8:3];
  assign binIdx  = inBinMain ? {1'b0, offBin[4:2]} : {3'b100, offExtra[2]};

  // Selected region, port and slot
  assign region  = inOct ? RXSC_OCTET : inErr ? RXSC_ERR : inBin ? RXSC_BIN : RXSC_NONE;
  assign selPort = inOct ? offOct[7:2] : inErr ? offErr[9:4] : binPort;
  assign selIdx  = inErr ? {2'b00, offErr[3:2]} : binIdx;

  // Write strobes per region
  assign wrOct = regWrite && (region == RXSC_OCTET);
  assign wrErr = regWrite && (region == RXSC_ERR);
  assign wrBin = regWrite && (region == RXSC_BIN);

  // Byte totals: write loads, else frame bytes add and wrap
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int p = 0; p < NPORTS; p++) begin
        octetTotal[p] <= OCTET_RESET;
      end
    end else begin
      for (int p = 0; p < NPORTS; p++) begin
        if (wrOct && selPort == PORT_W'(p)) begin
          octetTotal[p] <= regWdata[31:OCTET_LSB];
        end else if (frameOk && framePort == PORT_W'(p)) begin
          octetTotal[p] <= octetTotal[p] + OCTET_W'(frameLen);
        end
      end
    end
  end

  // Error counters
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int p = 0; p < NPORTS; p++) begin
        for (int e = 0; e < NUM_ERR; e++) begin
          errCount[p][e] <= CNT_RESET;
        end
      end
    end else begin
      for (int p = 0; p < NPORTS; p++) begin
        for (int e = 0; e < NUM_ERR; e++) begin
          if (wrErr && selPort == PORT_W'(p) && selIdx == IDX_W'(e)) begin
            errCount[p][e] <= regWdata[31:CNT_LSB];
          end else if (frameOk && framePort == PORT_W'(p) && errInc[e]) begin
            errCount[p][e] <= errCount[p][e] + CNT_W'(1);
          end
        end
      end
    end
  end

  // Histogram counters
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int p = 0; p < NPORTS; p++) begin
        for (int b = 0; b < NUM_BIN; b++) begin
          binCount[p][b] <= CNT_RESET;
        end
      end
    end else begin
      for (int p = 0; p < NPORTS; p++) begin
        for (int b = 0; b < NUM_BIN; b++) begin
          if (wrBin && selPort == PORT_W'(p) && selIdx == IDX_W'(b)) begin
            binCount[p][b] <= regWdata[31:CNT_LSB];
          end else if (frameOk && framePort == PORT_W'(p) && binInc[b]) begin
            binCount[p][b] <= binCount[p][b] + CNT_W'(1);
          end
        end
      end
    end
  end

  // Read mux; fields sit at their slot positions, low bits zero
  always_comb begin
    next_regRdata = 32'h0000_0000;
    if (regRead) begin
      case (region)
        RXSC_OCTET: next_regRdata = {octetTotal[selPort], 4'h0};
        RXSC_ERR:   next_regRdata = {errCount[selPort][selIdx[1:0]], 10'h000};
        RXSC_BIN:   next_regRdata = {binCount[selPort][selIdx], 10'h000};
        default:    next_regRdata = 32'h0000_0000;
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      regRdata <= 32'h0000_0000;
    end else begin
      regRdata <= next_regRdata;
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  logic octHitSame;
  logic errHitSame;
  logic binHitSame;
  assign octHitSame = wrOct && selPort == framePort;
  assign errHitSame = wrErr && selPort == framePort;
  assign binHitSame = wrBin && selPort == framePort;

  property p_octet_add;
    frameOk && !octHitSame |=> octetTotal[$past(framePort)] ==
      OCTET_W'($past(octetTotal[framePort]) + OCTET_W'($past(frameLen)));
  endproperty
  a_octet_add: assert property (p_octet_add) else $error("byte total not advanced");

  property p_align;
    frameOk && frameFcsBad && frameDribble && frameLen >= LEN_64 && !errHitSame
      |=> errCount[$past(framePort)][ERR_ALIGN] ==
          CNT_W'($past(errCount[framePort][ERR_ALIGN]) + 1);
  endproperty
  a_align: assert property (p_align) else $error("alignment count missed");

  property p_crc;
    frameOk && frameFcsBad && !frameDribble && frameLen >= LEN_64 && !errHitSame
      |=> errCount[$past(framePort)][ERR_CRC] ==
          CNT_W'($past(errCount[framePort][ERR_CRC]) + 1);
  endproperty
  a_crc: assert property (p_crc) else $error("crc count missed");

  property p_code;
    frameOk && frameFcsBad && frameCodeErr && !frameDribble && frameLen >= LEN_64
      && !errHitSame |=> errCount[$past(framePort)][ERR_CODE] ==
      CNT_W'($past(errCount[framePort][ERR_CODE]) + 1);
  endproperty
  a_code: assert property (p_code) else $error("code error count missed");

  property p_frag;
    frameOk && frameFcsBad && frameLen < LEN_64 && !errHitSame
      |=> errCount[$past(framePort)][ERR_FRAG] ==
          CNT_W'($past(errCount[framePort][ERR_FRAG]) + 1);
  endproperty
  a_frag: assert property (p_frag) else $error("fragment count missed");

  property p_wrap;
    frameOk && errInc[ERR_FRAG] && !errHitSame && (&errCount[framePort][ERR_FRAG])
      |=> errCount[$past(framePort)][ERR_FRAG] == CNT_RESET;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap to zero");

  property p_bin64;
    frameOk && !frameFcsBad && frameLen == LEN_64 && !binHitSame
      |=> binCount[$past(framePort)][BIN_64] ==
          CNT_W'($past(binCount[framePort][BIN_64]) + 1);
  endproperty
  a_bin64: assert property (p_bin64) else $error("64-byte bin missed");

  property p_jumbo;
    frameOk && !frameFcsBad && frameLen > LEN_1522 && frameLen < LEN_16384 && !binHitSame
      |=> binCount[$past(framePort)][BIN_JUMBO] ==
          CNT_W'($past(binCount[framePort][BIN_JUMBO]) + 1);
  endproperty
  a_jumbo: assert property (p_jumbo) else $error("jumbo bin missed");

  property p_runt;
    frameOk && frameFcsBad |=> binCount[$past(framePort)][BIN_RUNT] ==
      $past(binCount[framePort][BIN_RUNT]) || $past(binHitSame);
  endproperty
  a_runt: assert property (p_runt) else $error("errored frame reached runt bin");

  property p_over;
    frameOk && frameLen >= LEN_16384 && !binHitSame
      |=> binCount[$past(framePort)][BIN_OVER] ==
          CNT_W'($past(binCount[framePort][BIN_OVER]) + 1);
  endproperty
  a_over: assert property (p_over) else $error("oversized bin missed");

  property p_load;
    wrOct ##1 regRead && $past(selPort) == selPort && region == RXSC_OCTET
      |=> regRdata[31:OCTET_LSB] == $past(regWdata[31:OCTET_LSB], 2);
  endproperty
  a_load: assert property (p_load) else $error("written byte total not read back");

  property p_collide;
    wrErr && frameOk && framePort == selPort
      |=> errCount[$past(selPort)][$past(selIdx[1:0])] == $past(regWdata[31:CNT_LSB]);
  endproperty
  a_collide: assert property (p_collide) else $error("write lost to increment");

  // A histogram write lands in the addressed slot even when a frame hits it
  property p_load_bin;
    wrBin |=> binCount[$past(selPort)][$past(selIdx)] == $past(regWdata[31:CNT_LSB]);
  endproperty
  a_load_bin: assert property (p_load_bin) else $error("histogram write not loaded");

  // Read data stand only after a read strobe
  property p_rd_idle;
    !regRead |=> regRdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");

  property p_bin_small;
    frameOk && !frameFcsBad && frameLen > LEN_64 && frameLen <= LEN_127 && !binHitSame
      |=> binCount[$past(framePort)][BIN_64+1] ==
          CNT_W'($past(binCount[framePort][BIN_64+1]) + 1);
  endproperty
  a_bin_small: assert property (p_bin_small) else $error("65 to 127 bin missed");

  property p_bin_1522;
    frameOk && !frameFcsBad && frameLen > LEN_1518 && frameLen <= LEN_1522 && !binHitSame
      |=> binCount[$past(framePort)][BIN_JUMBO-1] ==
          CNT_W'($past(binCount[framePort][BIN_JUMBO-1]) + 1);
  endproperty
  a_bin_1522: assert property (p_bin_1522) else $error("1519 to 1522 bin missed");

  property p_runt_good;
    frameOk && !frameFcsBad && frameLen < LEN_64 && !binHitSame
      |=> binCount[$past(framePort)][BIN_RUNT] ==
          CNT_W'($past(binCount[framePort][BIN_RUNT]) + 1);
  endproperty
  a_runt_good: assert property (p_runt_good) else $error("runt bin missed");

  // Oversized good frames stay out of the jumbo bin
  property p_over_only;
    frameOk && !frameFcsBad && frameLen >= LEN_16384 && !binHitSame
      |=> binCount[$past(framePort)][BIN_JUMBO] == $past(binCount[framePort][BIN_JUMBO]);
  endproperty
  a_over_only: assert property (p_over_only) else $error("oversized frame in jumbo bin");

  c_ten_gig: cover property (frameOk && framePort == TEN_GIG_PORT1);
  c_collide: cover property (wrErr && frameOk && framePort == selPort);
  c_wrap:    cover property (frameOk && errInc[ERR_FRAG] && (&errCount[framePort][ERR_FRAG]));
  c_read:    cover property (regRead && region == RXSC_BIN ##1 regRdata != 32'h0000_0000);
  c_wr_rd:   cover property (wrOct ##1 regRead);

endmodule
`default_nettype wire

// ### tb_rx_port_statistics_counters.sv
// Self-checking bench for the receive statistics counters
`timescale 1ns/1ps
`default_nettype none
module tb_rx_port_statistics_counters
  import rxsc_pkg::*;
();
  localparam int CM = (1 << CNT_W) - 1;
  localparam int OM = (1 << OCTET_W) - 1;

  logic              clock;
  logic              reset_n;
  logic [ADDR_W-1:0] regAddr;
  logic [31:0]       regWdata;
  logic              regWrite;
  logic              regRead;
  wire  logic [31:0] regRdata;
  wire  logic        frameValid;
  wire  logic [5:0]  framePort;
  wire  logic [15:0] frameLen;
  wire  logic        frameFcsBad;
  wire  logic        frameDribble;
  wire  logic        frameCodeErr;
  int                errorCnt;
  int                checkCount;
  int                cycles;
  int                octM [NUM_PORTS];
  int                errM [NUM_PORTS][NUM_ERR];
  int                binM [NUM_PORTS][NUM_BIN];

  rxsc_stat_counters #(.NPORTS(NUM_PORTS)) rxsc_stat_counters_i (
    .clock(clock), .reset_n(reset_n), .frameValid(frameValid), .framePort(framePort),
    .frameLen(frameLen), .frameFcsBad(frameFcsBad), .frameDribble(frameDribble),
    .frameCodeErr(frameCodeErr), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));

  rxsc_frame_src rxsc_frame_src_i (
    .clock(clock), .frameValid(frameValid), .framePort(framePort), .frameLen(frameLen),
    .frameFcsBad(frameFcsBad), .frameDribble(frameDribble), .frameCodeErr(frameCodeErr));

  // Free-running clock, 20 ns period
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      errorCnt++;
      finalReport();
    end
  end

  task automatic finalReport();
    $display("checks %0d mismatches %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      errorCnt++;
    end
  endtask

  // Register bus: one-cycle strobes, read data in the cycle after the strobe
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    d = regRdata;
  endtask

  // Write then read one slot with the strobes back to back
  task automatic wrrd(input logic [ADDR_W-1:0] a, input logic [31:0] dw,
                      output logic [31:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= dw;
    @(posedge clock);
    regWrite <= 1'b0;
    regRead  <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    d = regRdata;
  endtask

  // Slot address: kind 0 byte total, 1 error counter, 2 histogram bin
  function automatic logic [ADDR_W-1:0] slot(input int k, input int p, input int i);
    case (k)
      0: slot = OCTET_BASE + ADDR_W'(4 * p);
      1: slot = ERR_BASE + ADDR_W'(16 * p + 4 * i);
      default: slot = (i < 8) ? BIN_BASE + ADDR_W'(32 * p + 4 * i)
                              : BIN_BASE + BIN_MAIN_SIZE + ADDR_W'(8 * p + 4 * (i - 8));
    endcase
  endfunction

  function automatic logic [31:0] expv(input int k, input int p, input int i);
    case (k)
      0: expv = 32'(octM[p] << OCTET_LSB);
      1: expv = 32'(errM[p][i] << CNT_LSB);
      default: expv = 32'(binM[p][i] << CNT_LSB);
    endcase
  endfunction

  // Reference classification of one frame report
  task automatic model(input int p, input int l, input logic [2:0] f);
    int b;
    int e;
    int lim[6] = '{127, 255, 511, 1023, 1518, 1522};
    if (p >= NUM_PORTS) return;
    octM[p] = (octM[p] + l) & OM;
    if (f[2]) begin
      e = (l < 64) ? ERR_FRAG : (f[1] ? ERR_ALIGN : ERR_CRC);
      errM[p][e] = (errM[p][e] + 1) & CM;
      if (l >= 64 && !f[1] && f[0]) errM[p][ERR_CODE] = (errM[p][ERR_CODE] + 1) & CM;
    end
    b = -1;
    if (l >= 16384) b = BIN_OVER;
    else if (!f[2]) begin
      b = BIN_JUMBO;
      for (int j = 5; j >= 0; j--) if (l <= lim[j]) b = j + 1;
      if (l == 64) b = BIN_64;
      if (l < 64) b = BIN_RUNT;
    end
    if (b >= 0) binM[p][b] = (binM[p][b] + 1) & CM;
  endtask

  task automatic frame(input int p, input int l, input logic [2:0] f);
    rxsc_frame_src_i.send(PORT_W'(p), LEN_W'(l), f);
    model(p, l, f);
  endtask

  // Read every slot of every port and compare with the reference
  task automatic sweep(input string name);
    logic [31:0] d;
    for (int p = 0; p < NUM_PORTS; p++) begin
      rd(slot(0, p, 0), d);
      chk($sformatf("bytes %0d", p), expv(0, p, 0), d);
      for (int i = 0; i < NUM_ERR; i++) begin
        rd(slot(1, p, i), d);
        chk($sformatf("err %0d.%0d", p, i), expv(1, p, i), d);
      end
      for (int i = 0; i < NUM_BIN; i++) begin
        rd(slot(2, p, i), d);
        chk($sformatf("bin %0d.%0d", p, i), expv(2, p, i), d);
      end
    end
    $display("test %s done", name);
  endtask

  task automatic clr();
    octM = '{default: 0};
    errM = '{default: 0};
    binM = '{default: 0};
  endtask

  // Main sequence
  initial begin
    logic [31:0] d0;
    logic [31:0] d1;
    int          dl;
    int          lens[17] = '{63, 64, 65, 127, 128, 255, 256, 511, 512, 1023, 1024,
                              1518, 1519, 1522, 1523, 16383, 16384};
    int          pts[5] = '{0, 47, 48, 49, 50};
    logic [19:0] bad[5] = '{20'h4_6401, 20'h4_64C8, 20'h4_47D0, 20'h4_5B20, 20'h0_0000};
    reset_n  = 1'b0;
    regAddr  = '0;
    regWdata = '0;
    regWrite = 1'b0;
    regRead  = 1'b0;
    void'($urandom(32'h255f));
    clr();
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    // Reset values and unmapped places
    foreach (bad[i]) wr(bad[i], 32'hFFFF_FFF0);
    foreach (bad[i]) begin
      rd(bad[i], d0);
      chk("unmapped read", 32'h0000_0000, d0);
    end
    sweep("reset");
    // Every length boundary with every flag mix, back to back
    foreach (lens[n]) for (int f = 0; f < 8; f++) frame(pts[(n * 8 + f) % 5], lens[n], 3'(f));
    rxsc_frame_src_i.idle();
    sweep("boundaries");
    // Random traffic with random gaps
    repeat (400) begin
      frame($urandom_range(0, 55), $urandom_range(1, 17000), 3'($urandom % 8));
      if ($urandom % 4 == 0) rxsc_frame_src_i.idle();
    end
    rxsc_frame_src_i.idle();
    sweep("random");
    // Loaded values wrap silently and sampling recovers the delta
    wrrd(slot(0, 7, 0), 32'hFFFF_FFF0, d0);
    octM[7] = OM;
    chk("loaded bytes", 32'hFFFF_FFF0, d0);
    frame(7, 40, 3'b000);
    rxsc_frame_src_i.idle();
    rd(slot(0, 7, 0), d1);
    dl = int'(d1 >> 4) - int'(d0 >> 4);
    if (d1 < d0) dl = dl + (1 << OCTET_W);
    chk("sampled delta", 32'd40, 32'(dl));
    wr(slot(1, 7, ERR_FRAG), 32'hFFFF_FC00);
    errM[7][ERR_FRAG] = CM;
    wr(slot(2, 48, BIN_64), 32'hFFFF_FFFF);
    binM[48][BIN_64] = CM;
    frame(7, 40, 3'b100);
    frame(48, 64, 3'b000);
    rxsc_frame_src_i.idle();
    sweep("wrap");
    // Write and increment on one counter in the same cycle
    fork
      begin
        rxsc_frame_src_i.send(6'h05, 16'h00C8, 3'b100);
        rxsc_frame_src_i.idle();
      end
      wr(slot(1, 5, ERR_CRC), 32'h0001_2C00);
    join
    model(5, 200, 3'b100);
    errM[5][ERR_CRC] = 32'h0001_2C00 >> CNT_LSB;
    sweep("collision");
    // Reset in mid-run clears everything
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    clr();
    sweep("second reset");
    finalReport();
  end
endmodule
`default_nettype wire
